// ===== inc/aopc_pkg.sv
// Constants for the always-on power control register bank
package aopc_pkg;

  // Register byte addresses on the APB
  localparam logic [31:0] ADDR_HIB  = 32'h5000_0310;
  localparam logic [31:0] ADDR_PULL = 32'h5000_0314;
  localparam logic [31:0] ADDR_AON  = 32'h5000_0320;
  localparam logic [31:0] ADDR_GP   = 32'h5000_0324;
  localparam logic [31:0] ADDR_STAT = 32'h5000_0328;

  // Register widths
  localparam int HIB_W  = 7;
  localparam int PULL_W = 1;
  localparam int AON_W  = 15;
  localparam int GP_W   = 8;
  localparam int STAT_W = 7;

  // Reset values
  localparam logic [HIB_W-1:0]  HIB_RST  = 7'h0;
  localparam logic [PULL_W-1:0] PULL_RST = 1'h1;
  localparam logic [AON_W-1:0]  AON_RST  = 15'h8;
  localparam logic [GP_W-1:0]   GP_RST   = 8'h00;

  // Hibernation control fields
  localparam int HIB_MASK_MSB = 6;
  localparam int HIB_MASK_LSB = 2;
  localparam int HIB_POL_BIT  = 1;
  localparam int HIB_EN_BIT   = 0;

  // Always-on power control fields
  localparam int AON_TRIM_MSB  = 13;
  localparam int AON_TRIM_LSB  = 10;
  localparam int AON_CMP_BIT   = 9;
  localparam int AON_MODE_MSB  = 8;
  localparam int AON_MODE_LSB  = 7;
  localparam int AON_CHG_BIT   = 6;
  localparam int AON_HIMSK_BIT = 3;
  localparam int AON_LOMSK_BIT = 2;
  localparam int AON_RES_MSB   = 1;
  localparam int AON_RES_LSB   = 0;

  // General-purpose data fields
  localparam int GP_FILT_BIT = 7;
  localparam int GP_VDD_BIT  = 6;
  localparam int GP_VREF_BIT = 5;
  localparam int GP_SCR_MSB  = 3;
  localparam int GP_SCR_LSB  = 0;

  // Synchronised input vector positions, also status register layout
  localparam int IN_W         = 6;
  localparam int IN_WAKE_STAT = 0;
  localparam int IN_BOOST     = 1;
  localparam int IN_SLEEP     = 2;
  localparam int IN_POR_HI    = 3;
  localparam int IN_POR_LO    = 4;
  localparam int IN_LINK_AUTO = 5;
  localparam int STAT_WAKE_EV = 6;

  // Converter mode force encodings
  typedef enum logic [1:0] {
    AOPC_CONV_AUTO0 = 2'b00,
    AOPC_CONV_AUTO1 = 2'b01,
    AOPC_CONV_BUCK  = 2'b10,
    AOPC_CONV_BOOST = 2'b11
  } aopc_conv_e;

  // Rail link resistor encodings
  typedef enum logic [1:0] {
    AOPC_RES_OFF    = 2'b00,
    AOPC_RES_ON     = 2'b01,
    AOPC_RES_SLP_ON = 2'b10,
    AOPC_RES_AUTO   = 2'b11
  } aopc_res_e;

endpackage

// ===== hw/aopc_sync.sv
// Two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module aopc_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule // aopc_sync

// ===== hw/aopc_regs.sv
// Always-on power control register bank with APB slave
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R01: Five-bit wake pin mask, bits 6:2
// R02: Wake when status leaves one in hibernation
// R03: Hibernation enable switches sleep domain off in sleep
// R04: Software sets boot remap before hibernating
// R05: Pull override resets one, forces pull-up boost
// R06: Retention clamp trim bits 13:10, reset zero
// R07: Bit 9 turns comparator off in sleep
// R08: Mode force: 0x auto, 11 boost, 10 buck
// R09: Bit 6 stops high rail charging boost
// R10: Bit 3 masks high detector reset, default set
// R11: Bit 2 masks low detector reset, default clear
// R12: Resistor control: off, on, sleep-on, auto
// R13: Bit 7 zero enables pin RC filter
// R14: Bit 6 ties oscillator bias to supply
// R15: Bit 5 selects reference bias source
// R16: Scratch bits 3:0 plain storage, reset zero
module aopc_regs (
  input  wire logic        core_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Analog and power-manager levels, asynchronous
  input  wire logic        clockless_wake_status,
  input  wire logic        boost_detected,
  input  wire logic        sleep_active,
  input  wire logic        por_vbat_high_req,
  input  wire logic        por_vbat_low_req,
  input  wire logic        rail_link_auto_req,
  // Controls toward the always-on domain
  output logic [4:0]       wake_pin_mask,
  output logic             wake_polarity,
  output logic             hibernation_enable,
  output logic             sleep_power_domain_on,
  output logic             wake_event,
  output logic             pull_up_force,
  output logic [3:0]       retention_clamp_trim,
  output logic             sleep_comparator_off,
  output logic             converter_boost,
  output logic             converter_forced,
  output logic             vbat_charge_off,
  output logic             por_vbat_high_rst,
  output logic             por_vbat_low_rst,
  output logic             rail_link_resistor_on,
  output logic             pin_rc_filter_en,
  output logic             slow_osc_bias_to_supply,
  output logic             slow_osc_bias_to_reference
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [aopc_pkg::HIB_W-1:0]  hib_r;
  logic [aopc_pkg::PULL_W-1:0] pull_r;
  logic [aopc_pkg::AON_W-1:0]  aon_r;
  logic [aopc_pkg::GP_W-1:0]   gp_r;
  logic [aopc_pkg::IN_W-1:0]   in_s;
  logic                        wake_stat_d_r;
  logic                        wake_ev_r;
  logic                        wake_seen_r;
  logic                        access;
  logic                        wr_en;
  logic                        rd_en;
  logic                        hit;
  logic [31:0]                 rd_nxt;
  logic [31:0]                 prdata_r;
  logic                        pready_r;
  logic                        pslverr_r;
  logic                        boost_nxt;
  logic                        hibernating;
  logic [1:0]                  mode_fld;
  logic [1:0]                  res_fld;
  logic                        res_nxt;

  logic                        sleep_pd_on_r;
  logic                        pull_up_r;
  logic                        cmp_off_r;
  logic                        conv_boost_r;
  logic                        conv_forced_r;
  logic                        chg_off_r;
  logic                        por_hi_r;
  logic                        por_lo_r;
  logic                        res_on_r;
  logic                        filt_en_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  aopc_sync #(
    .W (aopc_pkg::IN_W)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .d        ({rail_link_auto_req, por_vbat_low_req, por_vbat_high_req,
                sleep_active, boost_detected, clockless_wake_status}),
    .q        (in_s)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // APB handshake

  // One wait state keeps every bus output registered
  assign access = psel && penable;
  assign wr_en  = access && pready_r && pwrite;
  assign rd_en  = access && !pready_r && !pwrite;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= access && !pready_r;
    end
  end

  always_comb begin
    hit = 1'b1;
    case (paddr)
      aopc_pkg::ADDR_HIB:  rd_nxt = {25'h0, hib_r};
      aopc_pkg::ADDR_PULL: rd_nxt = {31'h0, pull_r};
      aopc_pkg::ADDR_AON:  rd_nxt = {17'h0, aon_r};
      aopc_pkg::ADDR_GP:   rd_nxt = {24'h000000, gp_r};
      aopc_pkg::ADDR_STAT: rd_nxt = {25'h0, wake_seen_r, in_s};
      default: begin
        hit    = 1'b0;
        rd_nxt = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else if (access && !pready_r) begin
      prdata_r  <= rd_en ? rd_nxt : 32'h00000000;
      pslverr_r <= !hit;
    end else begin
      pslverr_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hib_r <= aopc_pkg::HIB_RST;
    end else if (wr_en && paddr == aopc_pkg::ADDR_HIB) begin
      hib_r <= pwdata[aopc_pkg::HIB_W-1:0]; // [R01]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pull_r <= aopc_pkg::PULL_RST; // [R05]
    end else if (wr_en && paddr == aopc_pkg::ADDR_PULL) begin
      pull_r <= pwdata[aopc_pkg::PULL_W-1:0];
    end
  end

  // Reserved bits stay writable so software sees what it wrote
  always_ff @(posedge core_clk) begin
    if (rst) begin
      aon_r <= aopc_pkg::AON_RST; // [R06] [R10] [R11]
    end else if (wr_en && paddr == aopc_pkg::ADDR_AON) begin
      aon_r <= pwdata[aopc_pkg::AON_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      gp_r <= aopc_pkg::GP_RST; // [R16]
    end else if (wr_en && paddr == aopc_pkg::ADDR_GP) begin
      gp_r <= pwdata[aopc_pkg::GP_W-1:0]; // [R16]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Field decode

  assign mode_fld    = aon_r[aopc_pkg::AON_MODE_MSB:aopc_pkg::AON_MODE_LSB];
  assign res_fld     = aon_r[aopc_pkg::AON_RES_MSB:aopc_pkg::AON_RES_LSB];
  assign hibernating = in_s[aopc_pkg::IN_SLEEP] && hib_r[aopc_pkg::HIB_EN_BIT];

  always_comb begin
    case (aopc_pkg::aopc_conv_e'(mode_fld))
      aopc_pkg::AOPC_CONV_BOOST: boost_nxt = 1'b1; // [R08]
      aopc_pkg::AOPC_CONV_BUCK:  boost_nxt = 1'b0; // [R08]
      default:                   boost_nxt = in_s[aopc_pkg::IN_BOOST]; // [R08]
    endcase
  end

  always_comb begin
    case (aopc_pkg::aopc_res_e'(res_fld))
      aopc_pkg::AOPC_RES_OFF:    res_nxt = 1'b0; // [R12]
      aopc_pkg::AOPC_RES_ON:     res_nxt = 1'b1; // [R12]
      aopc_pkg::AOPC_RES_SLP_ON: res_nxt = in_s[aopc_pkg::IN_SLEEP] ||
                                           in_s[aopc_pkg::IN_LINK_AUTO]; // [R12]
      default:                   res_nxt = in_s[aopc_pkg::IN_LINK_AUTO]; // [R12]
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sleep and wake

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sleep_pd_on_r <= 1'b1;
    end else begin
      sleep_pd_on_r <= !hibernating; // [R03]
    end
  end

  // Status is trusted only while hibernating; software set polarity for a one
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wake_stat_d_r <= 1'b0;
      wake_ev_r     <= 1'b0;
    end else begin
      wake_stat_d_r <= in_s[aopc_pkg::IN_WAKE_STAT];
      wake_ev_r     <= hibernating && wake_stat_d_r
                       && !in_s[aopc_pkg::IN_WAKE_STAT]; // [R02]
    end
  end

  // Sticky record, cleared by a status read; a new event wins over the clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wake_seen_r <= 1'b0;
    end else if (wake_ev_r) begin
      wake_seen_r <= 1'b1; // [R02]
    end else if (wr_en == 1'b0 && access && pready_r && !pwrite
                 && paddr == aopc_pkg::ADDR_STAT) begin
      wake_seen_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Converter and supply controls

  always_ff @(posedge core_clk) begin
    if (rst) begin
      conv_boost_r  <= 1'b0;
      conv_forced_r <= 1'b0;
    end else begin
      conv_boost_r  <= boost_nxt; // [R08]
      conv_forced_r <= mode_fld[1]; // [R08]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pull_up_r <= 1'b0;
    end else begin
      pull_up_r <= pull_r[0] && boost_nxt; // [R05]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      chg_off_r <= 1'b0;
    end else begin
      chg_off_r <= aon_r[aopc_pkg::AON_CHG_BIT] && boost_nxt; // [R09]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmp_off_r <= 1'b0;
    end else begin
      cmp_off_r <= aon_r[aopc_pkg::AON_CMP_BIT] && in_s[aopc_pkg::IN_SLEEP]; // [R07]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      res_on_r <= 1'b0;
    end else begin
      res_on_r <= res_nxt; // [R12]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Supply monitor reset masking

  // Gated after sync, so a pulse shorter than one clock may be lost
  always_ff @(posedge core_clk) begin
    if (rst) begin
      por_hi_r <= 1'b0;
      por_lo_r <= 1'b0;
    end else begin
      por_hi_r <= in_s[aopc_pkg::IN_POR_HI] && !aon_r[aopc_pkg::AON_HIMSK_BIT]; // [R10]
      por_lo_r <= in_s[aopc_pkg::IN_POR_LO] && !aon_r[aopc_pkg::AON_LOMSK_BIT]; // [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin filter

  always_ff @(posedge core_clk) begin
    if (rst) begin
      filt_en_r <= 1'b1;
    end else begin
      filt_en_r <= !gp_r[aopc_pkg::GP_FILT_BIT]; // [R13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata                     = prdata_r;
  assign pready                     = pready_r;
  assign pslverr                    = pslverr_r;
  assign wake_pin_mask              = hib_r[aopc_pkg::HIB_MASK_MSB:aopc_pkg::HIB_MASK_LSB]; // [R01]
  assign wake_polarity              = hib_r[aopc_pkg::HIB_POL_BIT]; // [R02]
  assign hibernation_enable         = hib_r[aopc_pkg::HIB_EN_BIT]; // [R03]
  assign sleep_power_domain_on      = sleep_pd_on_r;
  assign wake_event                 = wake_ev_r;
  assign pull_up_force              = pull_up_r;
  assign retention_clamp_trim       = aon_r[aopc_pkg::AON_TRIM_MSB:aopc_pkg::AON_TRIM_LSB]; // [R06]
  assign sleep_comparator_off       = cmp_off_r;
  assign converter_boost            = conv_boost_r;
  assign converter_forced           = conv_forced_r;
  assign vbat_charge_off            = chg_off_r;
  assign por_vbat_high_rst          = por_hi_r;
  assign por_vbat_low_rst           = por_lo_r;
  assign rail_link_resistor_on      = res_on_r;
  assign pin_rc_filter_en           = filt_en_r;
  assign slow_osc_bias_to_supply    = gp_r[aopc_pkg::GP_VDD_BIT]; // [R14]
  assign slow_osc_bias_to_reference = gp_r[aopc_pkg::GP_VREF_BIT]; // [R15]

endmodule // aopc_regs

// ===== sim/aopc_regs_assertions.sv
// Concurrent checks on the ports of the power control register bank
`timescale 1ns/1ps
module aopc_chk (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sleep_active,
  input wire logic        por_vbat_low_req,
  input wire logic        hibernation_enable,
  input wire logic        sleep_power_domain_on,
  input wire logic        wake_event,
  input wire logic        pull_up_force,
  input wire logic        sleep_comparator_off,
  input wire logic        converter_boost,
  input wire logic        vbat_charge_off,
  input wire logic        por_vbat_low_rst
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // One wait state, so ready lands two edges after setup
  a_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("ready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held over one cycle");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  a_dom_off: assert property (!sleep_power_domain_on |-> $past(hibernation_enable))
    else $error("sleep domain off without hibernation");
  a_wake_hib: assert property (wake_event |-> $past(hibernation_enable) ##1 !wake_event)
    else $error("wake pulse outside hibernation or too long");
  a_chg_boost: assert property (vbat_charge_off |-> converter_boost)
    else $error("charge stop outside boost");
  a_pull_boost: assert property (pull_up_force |-> converter_boost)
    else $error("pull-up forced outside boost");
  a_cmp_sleep: assert property (!sleep_active [*4] |-> !sleep_comparator_off)
    else $error("comparator off while awake");
  a_por_low: assert property (!por_vbat_low_req [*4] |-> !por_vbat_low_rst)
    else $error("low detector reset without request");
endmodule // aopc_chk

////////////////////////////////////////
bind aopc_regs aopc_chk aopc_chk_i (.core_clk, .rst, .psel, .penable, .prdata, .pready,
  .pslverr, .sleep_active, .por_vbat_low_req, .hibernation_enable, .sleep_power_domain_on,
  .wake_event, .pull_up_force, .sleep_comparator_off, .converter_boost, .vbat_charge_off,
  .por_vbat_low_rst);

// ===== sim/aopc_regs_tb.sv
// Self-checking bench for the power control register bank
`timescale 1ns/1ps
module aopc_regs_tb;
  logic        core_clk = 0;
  logic        rst = 1;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata;
  logic        clockless_wake_status = 1, boost_detected = 0, sleep_active = 0;
  logic        por_vbat_high_req = 1, por_vbat_low_req = 1, rail_link_auto_req = 0;
  logic [4:0]  wake_pin_mask;
  logic [3:0]  retention_clamp_trim;
  logic        pready, pslverr, wake_polarity, hibernation_enable, sleep_power_domain_on;
  logic        wake_event, pull_up_force, sleep_comparator_off, converter_boost;
  logic        converter_forced, vbat_charge_off, por_vbat_high_rst, por_vbat_low_rst;
  logic        rail_link_resistor_on, pin_rc_filter_en;
  logic        slow_osc_bias_to_supply, slow_osc_bias_to_reference;
  int          err_total = 0;
  int          n_compared = 0;

  aopc_regs aopc_regs_i (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .clockless_wake_status, .boost_detected, .sleep_active,
    .por_vbat_high_req, .por_vbat_low_req, .rail_link_auto_req, .wake_pin_mask,
    .wake_polarity, .hibernation_enable, .sleep_power_domain_on, .wake_event,
    .pull_up_force, .retention_clamp_trim, .sleep_comparator_off, .converter_boost,
    .converter_forced, .vbat_charge_off, .por_vbat_high_rst, .por_vbat_low_rst,
    .rail_link_resistor_on, .pin_rc_filter_en, .slow_osc_bias_to_supply,
    .slow_osc_bias_to_reference);

  always #5 core_clk = ~core_clk;

  ////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Request held until ready seen; no wait length assumed
  task automatic apb(logic w, logic [31:0] a, logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge core_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    // Sampled at the rising edge itself; only the watchdog ends a hang
    do @(posedge core_clk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(logic [31:0] a, logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'h1, a, d, q, e);
  endtask

  task automatic rd(logic [31:0] a, logic [31:0] x, string nm);
    logic [31:0] q;
    logic e;
    apb(1'h0, a, 32'h0, q, e);
    chk(nm, q, x);
  endtask

  // Long enough to flush the input synchronisers
  task automatic settle();
    repeat (5) @(negedge core_clk);
  endtask

  task automatic t_reset();
    settle();
    chk("dom", sleep_power_domain_on, 1'h1);
    chk("filt", pin_rc_filter_en, 1'h1);
    chk("por_hi", por_vbat_high_rst, 1'h0);
    chk("por_lo", por_vbat_low_rst, 1'h1);
    rd(aopc_pkg::ADDR_HIB, 32'h0, "hib");
    rd(aopc_pkg::ADDR_PULL, 32'h1, "pull");
    rd(aopc_pkg::ADDR_AON, 32'h8, "aon");
    rd(aopc_pkg::ADDR_GP, 32'h0, "gp");
    $display("Test reset done");
  endtask

  task automatic t_hib();
    logic f;
    f = 0;
    wr(aopc_pkg::ADDR_HIB, 32'h7F); // Boot remap assumed set beforehand
    rd(aopc_pkg::ADDR_HIB, 32'h7F, "hib");
    chk("mask", wake_pin_mask, 5'h1F);
    chk("pol", wake_polarity, 1'h1);
    chk("hib_en", hibernation_enable, 1'h1);
    sleep_active <= 1'h1;
    settle();
    chk("dom", sleep_power_domain_on, 1'h0);
    @(posedge core_clk);
    clockless_wake_status <= 1'h0;
    repeat (8) begin
      @(negedge core_clk);
      if (wake_event === 1'h1) f = 1;
    end
    chk("wake", f, 1'h1);
    rd(aopc_pkg::ADDR_STAT, 32'h5C, "stat");
    rd(aopc_pkg::ADDR_STAT, 32'h1C, "stat");
    wr(aopc_pkg::ADDR_HIB, 32'h7C);
    settle();
    chk("dom", sleep_power_domain_on, 1'h1);
    $display("Test hibernation done");
  endtask

  task automatic t_aon();
    logic b;
    // Boost sensed low, so only a forced 11 may show boost
    for (int m = 0; m < 4; m++) begin
      wr(aopc_pkg::ADDR_AON, 32'h2A44 | (m << 7));
      b = m[1] & m[0];
      settle();
      chk("boost", converter_boost, b);
      chk("forced", converter_forced, m[1]);
      chk("chg", vbat_charge_off, b);
      chk("pull", pull_up_force, b);
      chk("trim", retention_clamp_trim, 4'hA);
      chk("cmp", sleep_comparator_off, 1'h1);
      chk("por_hi", por_vbat_high_rst, 1'h1);
      chk("por_lo", por_vbat_low_rst, 1'h0);
    end
    wr(aopc_pkg::ADDR_PULL, 32'h0);
    rd(aopc_pkg::ADDR_PULL, 32'h0, "pull");
    chk("pull", pull_up_force, 1'h0);
    for (int s = 0; s < 2; s++) begin
      @(posedge core_clk);
      sleep_active <= (s == 0);
      rail_link_auto_req <= (s == 1);
      for (int r = 0; r < 4; r++) begin
        wr(aopc_pkg::ADDR_AON, r);
        settle();
        chk("res", rail_link_resistor_on, r == 1 || r == 2 || (r == 3 && s == 1));
      end
    end
    // Disable bit set while awake must not turn the comparator off
    wr(aopc_pkg::ADDR_AON, 32'h200);
    settle();
    chk("cmp", sleep_comparator_off, 1'h0);
    @(posedge core_clk);
    por_vbat_low_req <= 1'h0;
    settle();
    chk("por_lo", por_vbat_low_rst, 1'h0);
    $display("Test power control done");
  endtask

  task automatic t_gp();
    logic [31:0] d;
    for (int i = 0; i < 2; i++) begin
      d = i ? 32'h10 : 32'hEF;
      wr(aopc_pkg::ADDR_GP, d);
      rd(aopc_pkg::ADDR_GP, d, "gp");
      chk("filt", pin_rc_filter_en, !d[7]);
      chk("vdd", slow_osc_bias_to_supply, d[6]);
      chk("vref", slow_osc_bias_to_reference, d[5]);
    end
    $display("Test general data done");
  endtask

  task automatic t_err();
    logic [31:0] q;
    logic e;
    apb(1'h1, 32'h5000_031C, 32'hFFFF, q, e);
    chk("err", e, 1'h1);
    apb(1'h0, 32'h5000_031C, 32'h0, q, e);
    chk("err", e, 1'h1);
    chk("rdata", q, 32'h0);
    rd(aopc_pkg::ADDR_HIB, 32'h7C, "hib");
    $display("Test unmapped done");
  endtask

  task automatic tally_and_finish();
    $display("Compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'h0;
    t_reset();
    t_hib();
    t_aon();
    t_gp();
    t_err();
    tally_and_finish();
  end

  // Tests take well under a thousand cycles
  initial begin
    #200000;
    err_total++;
    tally_and_finish();
  end
endmodule // aopc_regs_tb
